// ==== hw/fpr_pkg.sv ====
// Package with register map, field layouts and ramp timing for the fan ramp
package fpr_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_RAMP_OPTION  = 8'h10;
    localparam logic [7:0] ADDR_CONFIG_LOCK  = 8'h40;
    localparam logic [7:0] ADDR_ACOUSTIC_A   = 8'h62;
    localparam logic [7:0] ADDR_ACOUSTIC_B   = 8'h63;

    localparam logic [7:0] RST_ACOUSTIC_A    = 8'h00;
    localparam logic [7:0] RST_ACOUSTIC_B    = 8'h00;
    localparam logic [7:0] RST_RAMP_OPTION   = 8'h00;
    localparam logic [7:0] ACOUSTIC_B_MASK   = 8'h77;
    localparam int         LOCK_BIT          = 0;

    // ****************************************************************
    // Field layouts
    // ****************************************************************
    typedef struct packed {
        logic       fan_drive_3_floor_select;
        logic       fan_drive_2_floor_select;
        logic       fan_drive_1_floor_select;
        logic       tach_align_all;
        logic       remote1_smoothing_on;
        logic [2:0] remote1_ramp_rate;
    } fpr_acoustic_a_s;

    typedef struct packed {
        logic       rsvd_hi;
        logic [2:0] remote2_ramp_rate;
        logic       rsvd_lo;
        logic [2:0] local_ramp_rate;
    } fpr_acoustic_b_s;

    typedef struct packed {
        logic       slow_ramp;
        logic [3:0] rsvd;
        logic [2:0] quarter_rate;
    } fpr_ramp_option_s;

    // ****************************************************************
    // Ramp timing
    // ****************************************************************
    localparam int     NUM_CH         = 3;
    localparam int     DUTY_FULL      = 255;
    localparam longint CYC_PER_MS     = 64'd100000;
    localparam longint FAST_SWEEP_MS  = 64'd37500;
    localparam longint SLOW_SWEEP_MS  = 64'd52200;
    localparam longint FAST_SLOT_CYC  =
        FAST_SWEEP_MS * CYC_PER_MS / DUTY_FULL;
    localparam longint SLOW_SLOT_CYC  =
        SLOW_SWEEP_MS * CYC_PER_MS / DUTY_FULL;
    localparam int     SLOT_W         = 25;
    localparam logic [1:0] QUARTER_LAST = 2'h3;

endpackage : fpr_pkg

// ==== hw/fpr_fan_ramp.sv ====
// Fan drive duty ramp smoothing with acoustics registers
`timescale 1ns/1ps

module fpr_fan_ramp #(
    parameter logic [fpr_pkg::SLOT_W-1:0] FAST_SLOT =
        fpr_pkg::SLOT_W'(fpr_pkg::FAST_SLOT_CYC),
    parameter logic [fpr_pkg::SLOT_W-1:0] SLOW_SLOT =
        fpr_pkg::SLOT_W'(fpr_pkg::SLOW_SLOT_CYC)
) (
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] target_duty_1,
    input  wire logic [7:0] target_duty_2,
    input  wire logic [7:0] target_duty_3,
    input  wire logic [7:0] min_duty_1,
    input  wire logic [7:0] min_duty_2,
    input  wire logic [7:0] min_duty_3,
    input  wire logic [2:0] below_start,
    output logic      [7:0] fan_drive_1,
    output logic      [7:0] fan_drive_2,
    output logic      [7:0] fan_drive_3,
    output logic      [2:0] tach_align,
    output logic            config_locked
);
    import fpr_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] rate_inc(input logic [2:0] code);
        case (code)
            3'h0:    rate_inc = 8'h01;
            3'h1:    rate_inc = 8'h02;
            3'h2:    rate_inc = 8'h03;
            3'h3:    rate_inc = 8'h04;
            3'h4:    rate_inc = 8'h08;
            3'h5:    rate_inc = 8'h0C;
            3'h6:    rate_inc = 8'h18;
            default: rate_inc = 8'h30;
        endcase
    endfunction : rate_inc

    // ****************************************************************
    // Register file
    // ****************************************************************
    fpr_acoustic_a_s  acoustic_a;
    fpr_acoustic_b_s  acoustic_b;
    fpr_ramp_option_s ramp_option;
    logic             lock;
    logic       [7:0] rdata;
    fpr_acoustic_a_s  next_acoustic_a;
    fpr_acoustic_b_s  next_acoustic_b;
    fpr_ramp_option_s next_ramp_option;
    logic             next_lock;
    logic       [7:0] next_rdata;

    always_comb begin
        next_acoustic_a  = acoustic_a;
        next_acoustic_b  = acoustic_b;
        next_ramp_option = ramp_option;
        next_lock        = lock;
        next_rdata       = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_ACOUSTIC_A: begin
                    if (!lock) begin
                        next_acoustic_a = fpr_acoustic_a_s'(reg_wdata);
                    end
                end
                ADDR_ACOUSTIC_B: begin
                    if (!lock) begin
                        next_acoustic_b =
                            fpr_acoustic_b_s'(reg_wdata & ACOUSTIC_B_MASK);
                    end
                end
                ADDR_RAMP_OPTION: begin
                    next_ramp_option = fpr_ramp_option_s'(reg_wdata & 8'h87);
                end
                ADDR_CONFIG_LOCK: begin
                    // Lock only ever sets; reset is the sole way out
                    next_lock = lock | reg_wdata[LOCK_BIT];
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_ACOUSTIC_A:  next_rdata = acoustic_a;
                ADDR_ACOUSTIC_B:  next_rdata = acoustic_b;
                ADDR_RAMP_OPTION: next_rdata = ramp_option;
                ADDR_CONFIG_LOCK: next_rdata = {7'h00, lock};
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            acoustic_a  <= fpr_acoustic_a_s'(RST_ACOUSTIC_A);
            acoustic_b  <= fpr_acoustic_b_s'(RST_ACOUSTIC_B);
            ramp_option <= fpr_ramp_option_s'(RST_RAMP_OPTION);
            lock        <= 1'b0;
            rdata       <= 8'h00;
        end else begin
            acoustic_a  <= next_acoustic_a;
            acoustic_b  <= next_acoustic_b;
            ramp_option <= next_ramp_option;
            lock        <= next_lock;
            rdata       <= next_rdata;
        end
    end

    // ****************************************************************
    // Time slot generator
    // ****************************************************************
    logic [SLOT_W-1:0] slot_cnt;
    logic [SLOT_W-1:0] next_slot_cnt;
    logic [SLOT_W-1:0] slot_last;
    logic              slot_tick;

    always_comb begin
        // Slow option stretches every slot by the sweep-time ratio
        slot_last     = (ramp_option.slow_ramp ? SLOW_SLOT : FAST_SLOT)
                        - SLOT_W'(1);
        slot_tick     = (slot_cnt >= slot_last);
        next_slot_cnt = slot_tick ? '0 : slot_cnt + SLOT_W'(1);
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            slot_cnt <= '0;
        end else begin
            slot_cnt <= next_slot_cnt;
        end
    end

    // ****************************************************************
    // Per-channel ramp (ch 0 remote 1, ch 1 local, ch 2 remote 2)
    // ****************************************************************
    logic [7:0] goal   [NUM_CH];
    logic [7:0] target [NUM_CH];
    logic [7:0] mins   [NUM_CH];
    logic [2:0] code   [NUM_CH];
    logic       smooth [NUM_CH];
    logic [2:0] floor_sel;

    assign target[0] = target_duty_1;
    assign target[1] = target_duty_2;
    assign target[2] = target_duty_3;
    assign mins[0]   = min_duty_1;
    assign mins[1]   = min_duty_2;
    assign mins[2]   = min_duty_3;
    assign code[0]   = acoustic_a.remote1_ramp_rate;
    assign code[1]   = acoustic_b.local_ramp_rate;
    assign code[2]   = acoustic_b.remote2_ramp_rate;
    assign smooth[0] = acoustic_a.remote1_smoothing_on;
    assign smooth[1] = 1'b1;
    assign smooth[2] = 1'b1;
    assign floor_sel = {acoustic_a.fan_drive_3_floor_select,
                        acoustic_a.fan_drive_2_floor_select,
                        acoustic_a.fan_drive_1_floor_select};

    logic [7:0] duty [NUM_CH];
    logic [1:0] qdiv [NUM_CH];

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic [7:0] next_duty;
            logic [1:0] next_qdiv;
            logic       ch_tick;
            logic [7:0] inc;
            logic [7:0] gap;

            always_comb begin
                // Below start the goal is off or the programmed floor
                goal[g]   = below_start[g]
                          ? (floor_sel[g] ? mins[g] : 8'h00)
                          : target[g];
                inc       = rate_inc(code[g]);
                ch_tick   = slot_tick && (!ramp_option.quarter_rate[g]
                                          || qdiv[g] == QUARTER_LAST);
                next_qdiv = slot_tick ? qdiv[g] + 2'h1 : qdiv[g];
                gap       = (goal[g] > duty[g]) ? goal[g] - duty[g]
                                                : duty[g] - goal[g];
                next_duty = duty[g];
                if (!smooth[g]) begin
                    next_duty = goal[g];
                end else if (ch_tick) begin
                    // Clamp the step so the ramp lands on the goal exactly
                    if (goal[g] > duty[g]) begin
                        next_duty = (gap <= inc) ? goal[g]
                                                 : duty[g] + inc;
                    end else if (goal[g] < duty[g]) begin
                        next_duty = (gap <= inc) ? goal[g]
                                                 : duty[g] - inc;
                    end
                end
            end

            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    duty[g] <= 8'h00;
                    qdiv[g] <= 2'h0;
                end else begin
                    duty[g] <= next_duty;
                    qdiv[g] <= next_qdiv;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tach_align <= 3'h0;
        end else begin
            // Inputs 3 and 4 always follow drive 3; input 2 optionally
            tach_align <= {2'h3, acoustic_a.tach_align_all};
        end
    end

    assign reg_rdata     = rdata;
    assign fan_drive_1   = duty[0];
    assign fan_drive_2   = duty[1];
    assign fan_drive_3   = duty[2];
    assign config_locked = lock;

endmodule : fpr_fan_ramp

// ==== tb/fpr_fan_ramp_chk.sv ====
// Checker for the fan ramp register port and drive outputs
`timescale 1ns/1ps
module fpr_fan_ramp_chk (
    input wire logic       core_clk,
    input wire logic       reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] target_duty_2,
    input wire logic [2:0] below_start,
    input wire logic [7:0] fan_drive_2,
    input wire logic [7:0] fan_drive_3,
    input wire logic [2:0] tach_align,
    input wire logic       config_locked
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_wr_a;
        reg_wr && reg_addr == 8'h62 && !config_locked;
    endsequence
    sequence s_rd_a;
        reg_rd && reg_addr == 8'h62;
    endsequence
    property p_wr_rd_a;
        s_wr_a ##1 s_rd_a |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_wr_rd_a: assert property (p_wr_rd_a)
        else $error("register A read back differs from write");
    property p_lock_set;
        reg_wr && reg_addr == 8'h40 && reg_wdata[0] |=> config_locked;
    endproperty
    a_lock_set: assert property (p_lock_set)
        else $error("lock not set by write");
    property p_lock_keep;
        config_locked |=> config_locked;
    endproperty
    a_lock_keep: assert property (p_lock_keep)
        else $error("lock dropped without reset");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside read answer");
    property p_rsvd;
        reg_rd && reg_addr == 8'h63 |=> (reg_rdata & 8'h88) == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("register B spare bits read nonzero");
    property p_tach;
        reset_n |=> tach_align[2:1] == 2'b11;
    endproperty
    a_tach: assert property (p_tach)
        else $error("speed inputs 3 and 4 not aligned");
    property p_hold;
        $changed(fan_drive_3) |=> $stable(fan_drive_3);
    endproperty
    a_hold: assert property (p_hold)
        else $error("drive 3 changed on consecutive cycles");
    property p_step;
        (fan_drive_2 > $past(fan_drive_2) ? fan_drive_2 - $past(fan_drive_2)
         : $past(fan_drive_2) - fan_drive_2) <= 8'd48;
    endproperty
    a_step: assert property (p_step)
        else $error("drive 2 step above largest increment");
    property p_no_over;
        fan_drive_2 <= target_duty_2 && !below_start[1]
            |=> fan_drive_2 <= $past(target_duty_2);
    endproperty
    a_no_over: assert property (p_no_over)
        else $error("drive 2 overshot its target");
endmodule : fpr_fan_ramp_chk

bind fpr_fan_ramp fpr_fan_ramp_chk fpr_fan_ramp_chk_inst (.*);

// ==== tb/fpr_fan_model.sv ====
// Fan model that records the largest duty jump it is given
`timescale 1ns/1ps
module fpr_fan_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] duty,
    output logic      [7:0] max_step
);
    logic [7:0] last = 8'h00;
    initial max_step = 8'h00;
    // A real fan cannot follow a jump, so the worst one is what is heard
    always @(posedge core_clk) begin
        if (duty > last && duty - last > max_step) max_step <= duty - last;
        if (last > duty && last - duty > max_step) max_step <= last - duty;
        last <= duty;
    end
endmodule : fpr_fan_model

// ==== tb/tb_fpr_fan_ramp.sv ====
// Testbench for the fan ramp smoothing block
`timescale 1ns/1ps
module tb_fpr_fan_ramp;
    import fpr_pkg::*;
    logic core_clk = 0, reset_n = 0, wr = 0, rd = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, t1 = 0, t2 = 0, m1 = 0;
    logic [7:0] d1, d2, d3, step, v;
    logic [2:0] bs = 0, tach;
    logic lock;
    int mismatches = 0, n_tests = 0, cyc = 0, g;
    localparam int INC [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
    fpr_fan_ramp #(.FAST_SLOT(25'd4), .SLOW_SLOT(25'd6)) fpr_fan_ramp_inst (
        .core_clk(core_clk), .reset_n(reset_n), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .target_duty_1(t1), .target_duty_2(t2), .target_duty_3(8'h5A),
        .min_duty_1(m1), .min_duty_2(8'h20), .min_duty_3(8'h30),
        .below_start(bs), .fan_drive_1(d1), .fan_drive_2(d2),
        .fan_drive_3(d3), .tach_align(tach), .config_locked(lock));
    fpr_fan_model fpr_fan_model_inst (.core_clk(core_clk), .duty(d2),
        .max_step(step));
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Called just after an edge; strobes last exactly one cycle
    task automatic wrt(input logic [7:0] a, d);
        wr <= 1; addr <= a; wdata <= d;
        @(posedge core_clk) wr <= 0;
    endtask : wrt
    // Read data is looked at mid-cycle, while it stands, not on its edge
    task automatic rdc(input logic [7:0] a, e);
        rd <= 1;
        addr <= a;
        @(posedge core_clk) rd <= 0;
        @(negedge core_clk) chk("rdata", rdata, e);
        @(posedge core_clk);
    endtask : rdc
    task automatic edges(input int n);
        repeat (n) @(posedge core_clk);
    endtask : edges
    // Cycles between two drive 2 changes, skipping a partial first slot
    task automatic gap2(output int n);
        logic [7:0] p;
        int k;
        for (k = 0; k < 2; k++) begin
            p = d2;
            n = 0;
            while (d2 === p && n < 200) begin
                @(posedge core_clk);
                n++;
            end
        end
    endtask : gap2
    task automatic final_report();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        edges(10);
        reset_n <= 1;
        edges(1);
        foreach (INC[i]) if (i < 5) rdc(8'h10 + 8'h10 * i, 8'h00);
        rdc(8'h62, 8'h00);
        rdc(8'h63, 8'h00);
        wrt(8'h55, 8'hFF);
        rdc(8'h55, 8'h00);
        wrt(8'h63, 8'hFF);
        rdc(8'h63, 8'h77);
        for (int c = 0; c < 8; c++) begin
            t2 <= 8'h00;
            for (g = 0; g < 3000 && d2 !== 8'h00; g++) edges(1);
            wrt(8'h63, 8'(c));
            t2 <= 8'hFF;
            for (g = 0; g < 300 && d2 === 8'h00; g++) edges(1);
            chk("first step", d2, 8'(INC[c]));
            for (g = 0; g < 3000 && d2 !== 8'hFF; g++) edges(1);
            edges(12);
            chk("settled", d2, 8'hFF);
        end
        wrt(8'h63, 8'h00);
        t2 <= 8'h00;
        foreach (INC[i]) if (i < 3) begin
            wrt(8'h10, i == 0 ? 8'h00 : i == 1 ? 8'h80 : 8'h02);
            gap2(g);
            chk("slot", 8'(g), i == 0 ? 8'd4 : i == 1 ? 8'd6 : 8'd16);
        end
        wrt(8'h10, 8'h00);
        t1 <= 8'd150;
        edges(2);
        chk("direct", d1, 8'd150);
        wrt(8'h62, 8'h08);
        t1 <= 8'd10;
        edges(2);
        chk("smoothed", 8'(d1 > 8'd140), 8'h01);
        wrt(8'h62, 8'h00);
        m1 <= 8'd40;
        bs <= 3'b001;
        edges(2);
        chk("floor off", d1, 8'h00);
        wrt(8'h62, 8'h20);
        edges(2);
        chk("floor min", d1, 8'd40);
        wrt(8'h62, 8'h10);
        edges(2);
        chk("align", {5'h00, tach}, 8'h07);
        wrt(8'h62, 8'hA5);
        rdc(8'h62, 8'hA5);
        wrt(8'h40, 8'h01);
        wrt(8'h62, 8'hFF);
        rdc(8'h62, 8'hA5);
        wrt(8'h63, 8'hFF);
        rdc(8'h63, 8'h00);
        chk("drive 3", d3, 8'h5A);
        chk("locked", {7'h00, lock}, 8'h01);
        chk("fan jump", 8'(step <= 8'd48), 8'h01);
        final_report();
    end
endmodule : tb_fpr_fan_ramp
